//--- pkg/slirq_pkg.sv
// Register map and field layout of the segment display interrupt bookkeeping block.
package slirq_pkg;
   localparam logic [7:0] ADDR_MASK_SET = 8'h00;
   localparam logic [7:0] ADDR_MASK_CLEAR = 8'h04;
   localparam logic [7:0] ADDR_MASK_VIEW = 8'h08;
   localparam logic [7:0] ADDR_FLAGS = 8'h0C;
   localparam int ADDR_W = 8;
   localparam int NSRC = 2;
   localparam int BIT_FRAME_END = 0;
   localparam int BIT_TURN_OFF = 2;
   localparam logic [NSRC-1:0] MASK_RESET = 2'h0;
   localparam logic [NSRC-1:0] FLAGS_RESET = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HSIZE_WORD = 2'h2;
endpackage : slirq_pkg

//--- hdl/slirq_flag.sv
`timescale 1ns/1ps
// One sticky event flag and its mask bit.
module slirq_flag (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic eventIn,
   input wire logic setMask,
   input wire logic clrMask,
   input wire logic readClr,
   output logic maskBit,
   output logic flagBit
);
   typedef struct packed {
      logic mask;
      logic flag;
   } slirq_flag_t;

   slirq_flag_t state_r;
   slirq_flag_t state_nxt;

   always_comb begin
      state_nxt = state_r;
      if (setMask) begin
         state_nxt.mask = 1'b1;
      end
      if (clrMask) begin
         state_nxt.mask = 1'b0;
      end
      if (readClr) begin
         state_nxt.flag = 1'b0;
      end
      if (eventIn) begin
         state_nxt.flag = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign maskBit = state_r.mask;
   assign flagBit = state_r.flag;
endmodule : slirq_flag

//--- hdl/slirq_top.sv
`timescale 1ns/1ps
// AHB-Lite slave holding the interrupt mask and sticky status of the segment display.
// Behaviour
// - writing one to disable clears mask
// - mask view reads one when source enabled
// - status bit 0 frame end, clears on read
// - status bit 2 turn off, clears on read
// - frame end bit 0, turn off bit 2
// - writing one to enable sets mask
module slirq_top (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic frameEndEvent,
   input wire logic turnOffEvent,
   output logic irqOut
);
   typedef struct packed {
      logic wrPend;
      logic [slirq_pkg::ADDR_W-1:0] addr;
      logic [31:0] rdata;
   } slirq_bus_t;

   slirq_bus_t bus_r;
   slirq_bus_t bus_nxt;
   logic [slirq_pkg::NSRC-1:0] events;
   logic [slirq_pkg::NSRC-1:0] maskBits;
   logic [slirq_pkg::NSRC-1:0] flagBits;
   logic [31:0] maskWord;
   logic [31:0] flagWord;
   logic addrPhase;
   logic doWrite;
   logic doRead;
   logic wrSet;
   logic wrClr;
   localparam logic [31:0] USED_BITS = (32'h0000_0001 << slirq_pkg::BIT_FRAME_END)
      | (32'h0000_0001 << slirq_pkg::BIT_TURN_OFF);

   assign events = {turnOffEvent, frameEndEvent};
   assign addrPhase = hsel && hready && (htrans == slirq_pkg::HTRANS_NONSEQ);
   assign doWrite = bus_r.wrPend;
   assign doRead = addrPhase && !hwrite
      && (haddr[slirq_pkg::ADDR_W-1:0] == slirq_pkg::ADDR_FLAGS);
   assign wrSet = doWrite && (bus_r.addr == slirq_pkg::ADDR_MASK_SET);
   assign wrClr = doWrite && (bus_r.addr == slirq_pkg::ADDR_MASK_CLEAR);

   always_comb begin
      maskWord = 32'h0000_0000;
      flagWord = 32'h0000_0000;
      maskWord[slirq_pkg::BIT_FRAME_END] = maskBits[0];
      maskWord[slirq_pkg::BIT_TURN_OFF] = maskBits[1];
      flagWord[slirq_pkg::BIT_FRAME_END] = flagBits[0];
      flagWord[slirq_pkg::BIT_TURN_OFF] = flagBits[1];
   end

   genvar i;
   generate
      for (i = 0; i < slirq_pkg::NSRC; i++) begin : g_src
         localparam int BITPOS = (i == 0) ? slirq_pkg::BIT_FRAME_END : slirq_pkg::BIT_TURN_OFF;
         slirq_flag u_flag (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .eventIn(events[i]),
            .setMask(wrSet && hwdata[BITPOS]),
            .clrMask(wrClr && hwdata[BITPOS]),
            .readClr(doRead),
            .maskBit(maskBits[i]),
            .flagBit(flagBits[i])
         );
      end
   endgenerate

   always_comb begin
      bus_nxt = bus_r;
      bus_nxt.wrPend = addrPhase && hwrite;
      if (addrPhase) begin
         bus_nxt.addr = haddr[slirq_pkg::ADDR_W-1:0];
         bus_nxt.rdata = 32'h0000_0000;
         if (!hwrite) begin
            case (haddr[slirq_pkg::ADDR_W-1:0])
               slirq_pkg::ADDR_MASK_VIEW: begin
                  bus_nxt.rdata = maskWord;
               end
               slirq_pkg::ADDR_FLAGS: begin
                  bus_nxt.rdata = flagWord;
               end
               default: begin
                  bus_nxt.rdata = 32'h0000_0000;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bus_r <= '0;
      end else begin
         bus_r <= bus_nxt;
      end
   end

   assign hrdata = bus_r.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign irqOut = |(maskBits & flagBits);

   property p_irq;
      @(posedge clk_sys) disable iff (!rst_n)
         (frameEndEvent && maskBits[0] && !(wrClr && hwdata[slirq_pkg::BIT_FRAME_END]))
         |=> irqOut;
   endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch");

   property p_setmask;
      @(posedge clk_sys) disable iff (!rst_n)
         (wrSet && hwdata[slirq_pkg::BIT_FRAME_END]) |=> maskBits[0];
   endproperty
   a_setmask: assert property (p_setmask) else $error("mask set failed");

   property p_clrmask;
      @(posedge clk_sys) disable iff (!rst_n)
         (wrClr && hwdata[slirq_pkg::BIT_TURN_OFF]) |=> !maskBits[1];
   endproperty
   a_clrmask: assert property (p_clrmask) else $error("mask clear failed");

   property p_keepmask;
      @(posedge clk_sys) disable iff (!rst_n)
         (wrClr && !hwdata[slirq_pkg::BIT_FRAME_END]) |=> maskBits[0] == $past(maskBits[0]);
   endproperty
   a_keepmask: assert property (p_keepmask) else $error("mask changed on zero");

   property p_frameflag;
      @(posedge clk_sys) disable iff (!rst_n) frameEndEvent |=> flagBits[0];
   endproperty
   a_frameflag: assert property (p_frameflag) else $error("frame flag lost");

   property p_offflag;
      @(posedge clk_sys) disable iff (!rst_n) turnOffEvent |=> flagBits[1];
   endproperty
   a_offflag: assert property (p_offflag) else $error("turn off flag lost");

   property p_readclr;
      @(posedge clk_sys) disable iff (!rst_n) (doRead && !frameEndEvent) |=> !flagBits[0];
   endproperty
   a_readclr: assert property (p_readclr) else $error("read did not clear");

   property p_view;
      @(posedge clk_sys) disable iff (!rst_n)
         (addrPhase && !hwrite && haddr[slirq_pkg::ADDR_W-1:0] == slirq_pkg::ADDR_MASK_VIEW)
         |=> hrdata == $past(maskWord);
   endproperty
   a_view: assert property (p_view) else $error("mask view wrong");

   property p_place;
      @(posedge clk_sys) disable iff (!rst_n) (hrdata & ~USED_BITS) == 32'h0000_0000;
   endproperty
   a_place: assert property (p_place) else $error("unused bit set");

   property p_setoff;
      @(posedge clk_sys) disable iff (!rst_n)
         (wrSet && hwdata[slirq_pkg::BIT_TURN_OFF]) |=> maskBits[1];
   endproperty
   a_setoff: assert property (p_setoff) else $error("turn off mask set failed");

   property p_keepset;
      @(posedge clk_sys) disable iff (!rst_n)
         (wrSet && !hwdata[slirq_pkg::BIT_TURN_OFF]) |=> maskBits[1] == $past(maskBits[1]);
   endproperty
   a_keepset: assert property (p_keepset) else $error("mask changed on zero set");

   property p_clrframe;
      @(posedge clk_sys) disable iff (!rst_n)
         (wrClr && hwdata[slirq_pkg::BIT_FRAME_END]) |=> !maskBits[0];
   endproperty
   a_clrframe: assert property (p_clrframe) else $error("frame mask clear failed");

   property p_readclroff;
      @(posedge clk_sys) disable iff (!rst_n) (doRead && !turnOffEvent) |=> !flagBits[1];
   endproperty
   a_readclroff: assert property (p_readclroff) else $error("read kept turn off flag");

   property p_flagview;
      @(posedge clk_sys) disable iff (!rst_n) doRead |=> hrdata == $past(flagWord);
   endproperty
   a_flagview: assert property (p_flagview) else $error("status read wrong");

   property p_sticky;
      @(posedge clk_sys) disable iff (!rst_n) (flagBits[0] && !doRead) |=> flagBits[0];
   endproperty
   a_sticky: assert property (p_sticky) else $error("frame flag dropped");

   property p_stickyoff;
      @(posedge clk_sys) disable iff (!rst_n) (flagBits[1] && !doRead) |=> flagBits[1];
   endproperty
   a_stickyoff: assert property (p_stickyoff) else $error("turn off flag dropped");

   property p_unmapped;
      @(posedge clk_sys) disable iff (!rst_n)
         (addrPhase && !hwrite && haddr[slirq_pkg::ADDR_W-1:0] != slirq_pkg::ADDR_MASK_VIEW
            && haddr[slirq_pkg::ADDR_W-1:0] != slirq_pkg::ADDR_FLAGS)
         |=> hrdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

   c_irq: cover property (@(posedge clk_sys) disable iff (!rst_n) irqOut);
   c_read: cover property (@(posedge clk_sys) disable iff (!rst_n) doRead && flagBits[0]);
   c_race: cover property (@(posedge clk_sys) disable iff (!rst_n) doRead && frameEndEvent);
   c_clear: cover property (@(posedge clk_sys) disable iff (!rst_n) wrClr && maskBits[0]);
   c_offread: cover property (@(posedge clk_sys) disable iff (!rst_n) doRead && flagBits[1]);
endmodule : slirq_top

//--- tb/testbench.sv
// Self-checking bench for the segment display interrupt register block.
`timescale 1ns/1ps
module testbench;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic frameEndEvent = 1'b0;
   logic turnOffEvent = 1'b0;
   logic irqOut;
   logic [1:0] maskM = 2'h0;
   logic [1:0] flagM = 2'h0;
   logic [31:0] rd;
   logic [31:0] d;
   int errors = 0;
   int samples_checked = 0;

   slirq_top slirq_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .frameEndEvent(frameEndEvent),
      .turnOffEvent(turnOffEvent), .irqOut(irqOut));

   function automatic logic [31:0] vw(input logic [1:0] m);
      vw = {29'h0, m[1], 1'b0, m[0]};
   endfunction : vw

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   task automatic cmp_irq(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: irq got %b expected %b", $time, got, exp);
      end
   endtask : cmp_irq

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= slirq_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      bus(1'b1, a, v);
      if (a == slirq_pkg::ADDR_MASK_SET) maskM = maskM | {v[2], v[0]};
      if (a == slirq_pkg::ADDR_MASK_CLEAR) maskM = maskM & ~{v[2], v[0]};
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      cmp(rd, exp);
      if (a == slirq_pkg::ADDR_FLAGS) flagM = 2'h0;
      #1 cmp_irq(irqOut, |(flagM & maskM));
   endtask : rdchk

   task automatic ev(input logic [1:0] e);
      @(posedge clk_sys);
      frameEndEvent <= e[0];
      turnOffEvent <= e[1];
      @(posedge clk_sys);
      frameEndEvent <= 1'b0;
      turnOffEvent <= 1'b0;
      flagM = flagM | e;
   endtask : ev

   task automatic end_sim();
      if (errors == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_sim

   initial begin
      forever #2 clk_sys = ~clk_sys;
   end

   initial begin
      #40000;
      errors++;
      end_sim();
   end

   initial begin
      void'($urandom(32'hE5F4));
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      rdchk(slirq_pkg::ADDR_MASK_VIEW, 32'h0);
      rdchk(slirq_pkg::ADDR_FLAGS, 32'h0);
      ev(2'h3);
      wr(slirq_pkg::ADDR_MASK_SET, 32'hFFFFFFFF);
      wr(slirq_pkg::ADDR_MASK_CLEAR, 32'h0);
      rdchk(slirq_pkg::ADDR_MASK_VIEW, 32'h5);
      rdchk(slirq_pkg::ADDR_FLAGS, 32'h5);
      rdchk(slirq_pkg::ADDR_FLAGS, 32'h0);
      d = vw(flagM);
      fork
         bus(1'b0, slirq_pkg::ADDR_FLAGS, 32'h0);
         ev(2'h1);
      join
      cmp(rd, d);
      flagM = 2'h1;
      rdchk(slirq_pkg::ADDR_FLAGS, vw(flagM));
      repeat (300) begin
         d = $urandom;
         case ($urandom % 6)
            0: wr(slirq_pkg::ADDR_MASK_SET, d);
            1: wr(slirq_pkg::ADDR_MASK_CLEAR, d);
            2: rdchk(slirq_pkg::ADDR_MASK_VIEW, vw(maskM));
            3: rdchk(slirq_pkg::ADDR_FLAGS, vw(flagM));
            4: ev(d[1:0]);
            default: begin
               wr({d[7:4] | 4'h1, d[3:2], 2'h0}, d);
               rdchk({d[7:4] | 4'h1, d[3:2], 2'h0}, 32'h0);
            end
         endcase
      end
      wr(slirq_pkg::ADDR_MASK_SET, 32'h5);
      ev(2'h3);
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      cmp(hrdata, 32'h0);
      cmp_irq(irqOut, 1'b0);
      rst_n <= 1'b1;
      maskM = 2'h0;
      flagM = 2'h0;
      rdchk(slirq_pkg::ADDR_MASK_VIEW, 32'h0);
      rdchk(slirq_pkg::ADDR_FLAGS, 32'h0);
      end_sim();
   end
endmodule : testbench
